// [pkg/sfts_pkg.sv]
`default_nettype none
package sfts_pkg;
    localparam int SFTS_DATA_WIDTH = 32;
    localparam int SFTS_ADDR_WIDTH = 18;
    localparam int SFTS_LANE_COUNT = 4;
    localparam int SFTS_LANE_WIDTH = 8;
    localparam int SFTS_BURST_BITS = 2;
    localparam logic [1:0] SFTS_BEAT_FIRST = 2'h0;
    localparam logic [1:0] SFTS_BEAT_STEP = 2'h1;
    localparam logic SFTS_ORDER_LINEAR = 1'h0;
    localparam logic SFTS_ORDER_INTERLEAVED = 1'h1;

    typedef enum logic [2:0] {
        SFTS_DESELECT = 3'h1,
        SFTS_READ = 3'h2,
        SFTS_WRITE = 3'h4
    } sfts_cycle_type;
endpackage
`default_nettype wire

// [hw/sfts_burst_step.sv]
`timescale 1ns/1ps
`default_nettype none
module sfts_burst_step
    import sfts_pkg::*;
(
    // Burst origin and beat
    input wire logic [SFTS_BURST_BITS-1:0] start_low,
    input wire logic [SFTS_BURST_BITS-1:0] beat,
    input wire logic burst_order_sel,
    // Resulting low address bits
    output logic [SFTS_BURST_BITS-1:0] burst_addr_low
);
    always_comb begin
        if (burst_order_sel == SFTS_ORDER_INTERLEAVED) begin
            burst_addr_low = start_low ^ beat;
        end else begin
            burst_addr_low = start_low + beat;
        end
    end
endmodule
`default_nettype wire

// [hw/sfts_mem_array.sv]
`timescale 1ns/1ps
`default_nettype none
module sfts_mem_array
    import sfts_pkg::*;
#(
    parameter int ADDR_WIDTH = SFTS_ADDR_WIDTH
) (
    // Clock
    input wire logic clock,
    // Write port
    input wire logic write_en,
    input wire logic [SFTS_LANE_COUNT-1:0] lane_en,
    input wire logic [ADDR_WIDTH-1:0] write_addr,
    input wire logic [SFTS_DATA_WIDTH-1:0] write_data,
    // Read port, combinational
    input wire logic [ADDR_WIDTH-1:0] read_addr,
    output logic [SFTS_DATA_WIDTH-1:0] read_data
);
    localparam int DEPTH = 2 ** ADDR_WIDTH;

    // One array per lane, so every array has a single writing process
    for (genvar lane = 0; lane < SFTS_LANE_COUNT; lane++) begin : g_lane
        // No reset: contents survive reset and low-power, like the cell array
        logic [SFTS_LANE_WIDTH-1:0] cell_q [DEPTH];

        assign read_data[lane*SFTS_LANE_WIDTH +: SFTS_LANE_WIDTH] = cell_q[read_addr];

        always_ff @(posedge clock) begin
            if (write_en && lane_en[lane]) begin
                cell_q[write_addr] <= write_data[lane*SFTS_LANE_WIDTH +: SFTS_LANE_WIDTH];
            end
        end
    end
endmodule
`default_nettype wire

// [hw/sfts_sram_core.sv]
// Overview of operation
// - Sample inputs on clock; three act asynchronously
// - Clock hold freezes state, bus, writes
// - Capture address only on selected load
// - Select needs 0,1,0; otherwise deselect, float
// - Advance steps burst; load takes new address
// - Load chooses read or write; advance keeps
// - Byte enables gate each lane's write
// - Drive data only selected with output enable
// - Strap high interleaved, low linear order
// - Interleaved order XORs start with beat
// - Linear order increments modulo four
// - Sleep deselects, keeps data while high
// - Sleep ignores inputs, floats outputs
// - Selected read load reads external address
// - Read advance reads next burst address
// - Output enable high makes dummy read
// - Write load starts write, drivers off
// - Write advance writes enabled bytes next
// - All byte enables high aborts write
// - Write data arrives one clock later
// - Two-bit counter wraps after four beats
// - Hold keeps read bus driven, write floating
`timescale 1ns/1ps
`default_nettype none
module sfts_sram_core
    import sfts_pkg::*;
#(
    parameter int ADDR_WIDTH = SFTS_ADDR_WIDTH
) (
    // Clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    // Address and command
    input wire logic [ADDR_WIDTH-1:0] addr_in,
    input wire logic chip_sel_0,
    input wire logic chip_sel_1,
    input wire logic chip_sel_2,
    input wire logic advance_or_load,
    input wire logic read_not_write,
    input wire logic [SFTS_LANE_COUNT-1:0] byte_write_n,
    input wire logic clock_hold_n,
    // Asynchronous controls
    input wire logic output_enable_n,
    input wire logic burst_order_sel,
    input wire logic sleep_request,
    // Data pins, split
    input wire logic [SFTS_DATA_WIDTH-1:0] data_in,
    output logic [SFTS_DATA_WIDTH-1:0] data_out,
    output logic data_oe
);
    sfts_cycle_type cycle_q, cycle_d;
    logic [ADDR_WIDTH-1:0] start_q, start_d;
    logic [SFTS_BURST_BITS-1:0] beat_q, beat_d;
    logic drive_q, drive_d;
    logic [SFTS_DATA_WIDTH-1:0] out_q, out_d;
    logic wr_pend_q, wr_pend_d;
    logic [ADDR_WIDTH-1:0] wr_addr_q, wr_addr_d;
    logic [SFTS_LANE_COUNT-1:0] wr_lanes_q, wr_lanes_d;

    logic edge_live;
    logic selected;
    logic [SFTS_BURST_BITS-1:0] next_beat;
    logic [SFTS_BURST_BITS-1:0] next_low;
    logic [ADDR_WIDTH-1:0] burst_addr;
    logic [ADDR_WIDTH-1:0] rd_addr;
    logic [SFTS_DATA_WIDTH-1:0] rd_raw;
    logic [SFTS_DATA_WIDTH-1:0] rd_merged;
    logic mem_we;

    // Sleep shuts every synchronous input off; hold masks the edge
    assign edge_live = !clock_hold_n && !sleep_request;
    assign selected = !chip_sel_0 && chip_sel_1 && !chip_sel_2;
    assign next_beat = beat_q + SFTS_BEAT_STEP;
    assign burst_addr = {start_q[ADDR_WIDTH-1:SFTS_BURST_BITS], next_low};
    assign rd_addr = advance_or_load ? burst_addr : addr_in;
    // Late write retires on the edge that carries its data
    assign mem_we = edge_live && wr_pend_q;

    sfts_burst_step u_step (
        .start_low(start_q[SFTS_BURST_BITS-1:0]),
        .beat(next_beat),
        .burst_order_sel(burst_order_sel),
        .burst_addr_low(next_low)
    );

    sfts_mem_array #(
        .ADDR_WIDTH(ADDR_WIDTH)
    ) u_mem (
        .clock(clock),
        .write_en(mem_we),
        .lane_en(wr_lanes_q),
        .write_addr(wr_addr_q),
        .write_data(data_in),
        .read_addr(rd_addr),
        .read_data(rd_raw)
    );

    // Forward lanes retiring this edge so read-after-write needs no dead cycle
    always_comb begin
        rd_merged = rd_raw;
        for (int lane = 0; lane < SFTS_LANE_COUNT; lane++) begin
            if (mem_we && wr_lanes_q[lane] && wr_addr_q == rd_addr) begin
                rd_merged[lane*SFTS_LANE_WIDTH +: SFTS_LANE_WIDTH] =
                    data_in[lane*SFTS_LANE_WIDTH +: SFTS_LANE_WIDTH];
            end
        end
    end

    always_comb begin
        cycle_d = cycle_q;
        start_d = start_q;
        beat_d = beat_q;
        drive_d = drive_q;
        out_d = out_q;
        wr_pend_d = wr_pend_q;
        wr_addr_d = wr_addr_q;
        wr_lanes_d = wr_lanes_q;
        if (sleep_request) begin
            // Pending work is dropped; the array itself keeps its data
            cycle_d = SFTS_DESELECT;
            drive_d = 1'b0;
            wr_pend_d = 1'b0;
        end else if (edge_live) begin
            wr_pend_d = 1'b0;
            if (!advance_or_load) begin
                if (!selected) begin
                    cycle_d = SFTS_DESELECT;
                    drive_d = 1'b0;
                end else begin
                    start_d = addr_in;
                    beat_d = SFTS_BEAT_FIRST;
                    if (read_not_write) begin
                        cycle_d = SFTS_READ;
                        drive_d = 1'b1;
                        out_d = rd_merged;
                    end else begin
                        cycle_d = SFTS_WRITE;
                        drive_d = 1'b0;
                        wr_pend_d = ~&byte_write_n;
                        wr_addr_d = addr_in;
                        wr_lanes_d = ~byte_write_n;
                    end
                end
            end else begin
                unique case (cycle_q)
                    SFTS_DESELECT: begin
                        drive_d = 1'b0;
                    end
                    SFTS_READ: begin
                        beat_d = next_beat;
                        drive_d = 1'b1;
                        out_d = rd_merged;
                    end
                    SFTS_WRITE: begin
                        beat_d = next_beat;
                        drive_d = 1'b0;
                        wr_pend_d = ~&byte_write_n;
                        wr_addr_d = burst_addr;
                        wr_lanes_d = ~byte_write_n;
                    end
                    // Only reachable before the first reset: park deselected
                    default: begin
                        cycle_d = SFTS_DESELECT;
                        drive_d = 1'b0;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            cycle_q <= SFTS_DESELECT;
            start_q <= '0;
            beat_q <= SFTS_BEAT_FIRST;
            drive_q <= 1'b0;
            out_q <= '0;
            wr_pend_q <= 1'b0;
            wr_addr_q <= '0;
            wr_lanes_q <= '0;
        end else begin
            cycle_q <= cycle_d;
            start_q <= start_d;
            beat_q <= beat_d;
            drive_q <= drive_d;
            out_q <= out_d;
            wr_pend_q <= wr_pend_d;
            wr_addr_q <= wr_addr_d;
            wr_lanes_q <= wr_lanes_d;
        end
    end

    assign data_out = out_q;
    // Output enable and sleep must float the pins without waiting for an edge
    assign data_oe = drive_q && !output_enable_n && !sleep_request;
endmodule
`default_nettype wire

// [verification/sfts_sram_core_props.sv]
`timescale 1ns/1ps
`default_nettype none
module sfts_sram_core_props
    import sfts_pkg::*;
#(
    parameter int ADDR_WIDTH = SFTS_ADDR_WIDTH
) (
    // Clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    // Command
    input wire logic [ADDR_WIDTH-1:0] addr_in,
    input wire logic chip_sel_0,
    input wire logic chip_sel_1,
    input wire logic chip_sel_2,
    input wire logic advance_or_load,
    input wire logic read_not_write,
    input wire logic [SFTS_LANE_COUNT-1:0] byte_write_n,
    input wire logic clock_hold_n,
    input wire logic output_enable_n,
    input wire logic burst_order_sel,
    input wire logic sleep_request,
    // Data
    input wire logic [SFTS_DATA_WIDTH-1:0] data_in,
    input wire logic [SFTS_DATA_WIDTH-1:0] data_out,
    input wire logic data_oe
);
    logic live;
    logic csel;
    logic rd_ld;
    assign live = !clock_hold_n && !sleep_request;
    assign csel = !chip_sel_0 && chip_sel_1 && !chip_sel_2;
    assign rd_ld = live && !advance_or_load && csel && read_not_write;
    default clocking @(posedge clock); endclocking
    default disable iff (sys_rst);
    oe_float_a: assert property (output_enable_n |-> !data_oe) else $error("oe float");
    sleep_float_a: assert property (sleep_request |-> !data_oe) else $error("sleep float");
    hold_data_a: assert property (clock_hold_n && !sleep_request |=> $stable(data_out)) else $error("hold");
    write_float_a: assert property (live && !advance_or_load && csel && !read_not_write |=> !data_oe)
        else $error("write drive");
    desel_float_a: assert property (live && !advance_or_load && !csel |=> !data_oe) else $error("desel");
    read_drive_a: assert property (rd_ld |=> data_oe || output_enable_n || sleep_request)
        else $error("read drive");
    read_adv_a: assert property (rd_ld ##1 live && advance_or_load |=> data_oe || output_enable_n || sleep_request)
        else $error("read adv");
    hold_bus_a: assert property (data_oe && clock_hold_n |=> data_oe || output_enable_n || sleep_request)
        else $error("hold bus");
endmodule
bind sfts_sram_core sfts_sram_core_props #(.ADDR_WIDTH(ADDR_WIDTH)) u_props (.clock, .sys_rst, .addr_in,
    .chip_sel_0, .chip_sel_1, .chip_sel_2, .advance_or_load, .read_not_write, .byte_write_n, .clock_hold_n,
    .output_enable_n, .burst_order_sel, .sleep_request, .data_in, .data_out, .data_oe);
`default_nettype wire

// [verification/sfts_ctrl_model.sv]
`timescale 1ns/1ps
`default_nettype none
module sfts_ctrl_model
    import sfts_pkg::*;
(
    // Command side
    input wire logic clock,
    input wire logic clock_hold_n,
    input wire logic wr_now,
    input wire logic [SFTS_DATA_WIDTH-1:0] wd,
    // Data pins
    output logic [SFTS_DATA_WIDTH-1:0] data_in
);
    initial data_in = '0;
    // Late data; inverted when idle so stale data never matches
    always @(posedge clock) if (!clock_hold_n) data_in <= #1 wr_now ? wd : ~data_in;
endmodule
`default_nettype wire

// [verification/tb_sfts_sram_core.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_sfts_sram_core;
    import sfts_pkg::*;
    logic clock = 0, sys_rst = 1, advance_or_load = 1, read_not_write = 1, clock_hold_n = 0, data_oe;
    logic output_enable_n = 0, burst_order_sel = 1, sleep_request = 0, wn = 0;
    logic [2:0] cs = 3'h6;
    logic [3:0] byte_write_n = 4'hF;
    logic [17:0] addr_in = 18'h0;
    logic [31:0] wd = 32'h0, data_in, data_out;
    logic [31:0] mem [int];
    int n_mismatch = 0, samples_checked = 0;
    always #2.5 clock = ~clock;
    sfts_sram_core dut_u (.clock, .sys_rst, .addr_in, .chip_sel_0(cs[2]), .chip_sel_1(cs[1]),
        .chip_sel_2(cs[0]), .advance_or_load, .read_not_write, .byte_write_n, .clock_hold_n,
        .output_enable_n, .burst_order_sel, .sleep_request, .data_in, .data_out, .data_oe);
    sfts_ctrl_model pm (.clock, .clock_hold_n, .wr_now(wn), .wd, .data_in);
    task automatic end_sim();
        if (n_mismatch == 0 && samples_checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic chk(string s, logic [31:0] e, logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            n_mismatch++;
            $display("unexpected %s exp %h seen %h", s, e, g);
        end
    endtask
    function automatic logic [17:0] ba(logic [17:0] s, logic [1:0] k);
        return {s[17:2], burst_order_sel ? s[1:0] ^ k : s[1:0] + k};
    endfunction
    task automatic go(logic a, logic [2:0] c, logic r, logic [3:0] b, logic [17:0] ad, logic w, logic [31:0] d);
        @(posedge clock);
        #1;
        {advance_or_load, cs, read_not_write, byte_write_n, addr_in, wn, wd} = {a, c, r, b, ad, w, d};
    endtask
    task automatic wburst(logic [17:0] s, logic [3:0] b);
        logic [31:0] d;
        for (int k = 0; k < 4; k++) begin
            d = {8'(k), 6'h0, s};
            go(k > 0, 3'h2, 0, b, s, 1, d);
            for (int l = 0; l < 4; l++)
                if (!b[l]) mem[ba(s, 2'(k))][8*l +: 8] = d[8*l +: 8];
        end
        go(0, 3'h6, 1, 4'hF, s, 0, 0);
    endtask
    task automatic rburst(logic [17:0] s);
        go(0, 3'h2, 1, 4'h0, s, 0, 0);
        for (int k = 0; k < 5; k++) begin
            // Select, direction and address must be ignored here
            go(1, 3'h6, 0, 4'h0, 18'h0, 0, 0);
            chk("read", mem[ba(s, 2'(k))], data_out);
            chk("drive", 1, data_oe);
        end
    endtask
    task automatic turn(logic [17:0] a, logic [3:0] b, logic [31:0] d, logic h);
        for (int l = 0; l < 4; l++)
            if (!b[l]) mem[a][8*l +: 8] = d[8*l +: 8];
        go(0, 3'h2, 0, b, a, 1, d);
        for (int k = 0; k < 2; k++) begin
            // First pass reads straight behind the write, second from the array
            go(0, 3'h2, 1, 4'hF, a, 0, 0);
            if (h && k == 0) begin
                // Hold lands on the late-data edge
                clock_hold_n = 1;
                go(0, 3'h2, 1, 4'hF, a, 0, 0);
                clock_hold_n = 0;
                chk("hold_wr", 0, data_oe);
            end
            go(0, 3'h6, 1, 4'hF, a, 0, 0);
            chk("turn", mem[a], data_out);
        end
    endtask
    task automatic rst_mid();
        sys_rst = 1;
        go(1, 3'h2, 1, 4'hF, 0, 0, 0);
        sys_rst = 0;
        go(1, 3'h2, 1, 4'hF, 0, 0, 0);
        // Reset leaves the part deselected, so an advance stays off the bus
        chk("rst_oe", 0, data_oe);
    endtask
    task automatic misc();
        go(0, 3'h2, 1, 4'hF, 18'h102, 0, 0);
        go(1, 3'h2, 1, 4'hF, 0, 0, 0);
        clock_hold_n = 1;
        go(1, 3'h2, 1, 4'hF, 0, 0, 0);
        clock_hold_n = 0;
        chk("hold", mem[18'h102], data_out);
        chk("hold_oe", 1, data_oe);
        go(1, 3'h2, 1, 4'hF, 0, 0, 0);
        chk("beat1", mem[ba(18'h102, 1)], data_out);
        output_enable_n = 1;
        #1;
        chk("oe_off", 0, data_oe);
        go(1, 3'h2, 1, 4'hF, 0, 0, 0);
        output_enable_n = 0;
        go(1, 3'h2, 1, 4'hF, 0, 0, 0);
        chk("dummy", mem[ba(18'h102, 3)], data_out);
        for (int i = 0; i < 3; i++) begin
            go(0, 3'(6 - 3 * i), 1, 4'hF, 18'h100, 0, 0);
            repeat (2) begin
                go(1, 3'h2, 1, 4'hF, 0, 0, 0);
                chk("desel", 0, data_oe);
            end
        end
        go(0, 3'h2, 1, 4'hF, 18'h100, 0, 0);
        go(0, 3'h6, 1, 4'hF, 0, 0, 0);
        // Raised while the read data is still driven, before the deselect is sampled
        sleep_request = 1;
        #1;
        chk("sleep_oe", 0, data_oe);
        go(0, 3'h2, 0, 4'h0, 18'h100, 1, 0);
        go(1, 3'h2, 0, 4'h0, 0, 1, 0);
        // Leave with a deselect, then a read
        go(0, 3'h6, 1, 4'hF, 0, 0, 0);
        sleep_request = 0;
        rburst(18'h100);
    endtask
    initial begin
        repeat (12) @(posedge clock);
        #1;
        sys_rst = 0;
        burst_order_sel = 0;
        wburst(18'h102, 4'h0);
        burst_order_sel = 1;
        rburst(18'h101);
        wburst(18'h103, 4'hA);
        burst_order_sel = 0;
        rburst(18'h100);
        wburst(18'h100, 4'hF);
        rburst(18'h102);
        turn(18'h101, 4'h5, 32'h5AC3_3CA5, 0);
        turn(18'h103, 4'h0, 32'hC35A_A53C, 1);
        misc();
        rst_mid();
        end_sim();
    end
    initial begin
        #20000;
        n_mismatch++;
        end_sim();
    end
endmodule
`default_nettype wire
